/* sdl_pkg.sv */
// constants, register map and types for the single pin debug link
// assumes one 20 MHz core clock and an apb master on that clock
// Notes on behaviour
// - one open drain pin, half duplex only
// - frame: start, eight data lsb first, stop
// - time eight low bits to set bit rate
// - core clock autobaud, bit down to clk/512
// - nine low bits is break, relock
// - low stop bit flags framing error
// - line low while releasing is collision
// - on error abort, send 4096 cycle break
// - host break keeps control and debug mode
// - debugger held until line returns high
// - debug mode stops fetch, refreshes watchdog
// - enter by write, breakpoint, or strap
// - leave by clearing bit or reset
// - line low in stop mode resets system
// - opcode 00h breakpoint, else no operation
// - loop mode spins, still serves interrupts
// - status shows cpu looping on breakpoint
// - clear loop enable to stop looping cpu
// - full commands only stopped in debug mode
// - read protect blocks clearing debug mode
package sdl_pkg;
  // apb byte offsets
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STAT_OFS = 12'h004;
  localparam logic [11:0] RXD_OFS = 12'h008;
  localparam logic [11:0] TXD_OFS = 12'h00C;
  // control field positions
  localparam int CTRL_DMODE_BIT = 7;
  localparam int CTRL_BKEN_BIT = 6;
  localparam int CTRL_LOOP_BIT = 5;
  // status field positions
  localparam int STAT_DMODE_BIT = 0;
  localparam int STAT_LOOP_BIT = 1;
  localparam int STAT_LOCK_BIT = 2;
  localparam int STAT_RXV_BIT = 3;
  localparam int STAT_TXB_BIT = 4;
  localparam int STAT_FRM_BIT = 5;
  localparam int STAT_COL_BIT = 6;
  localparam int STAT_BRK_BIT = 7;
  // reset values
  localparam logic CTRL_DMODE_RST = 1'b0;
  localparam logic CTRL_BKEN_RST = 1'b0;
  localparam logic CTRL_LOOP_RST = 1'b0;
  // timing counts in core clock cycles
  localparam int SYNC_BITS = 8;
  localparam int BREAK_BITS = 9;
  localparam int MIN_DIV = 512;
  localparam int MIN_BIT = 4;
  localparam logic [12:0] SYNC_MIN = 13'(SYNC_BITS * MIN_BIT);
  localparam logic [12:0] SYNC_MAX = 13'(SYNC_BITS * MIN_DIV);
  localparam logic [12:0] UNLK_BRK_CYC = 13'(BREAK_BITS * MIN_DIV);
  localparam logic [12:0] BRK_TX_CYC = 13'h1000;
  localparam logic [12:0] HOLD_HI_CYC = 13'h0003;
  localparam logic [12:0] CNT_MAX = 13'h1FFF;
  localparam logic [1:0] STRAP_CHK = 2'h2;
  localparam logic [1:0] STRAP_DONE = 2'h3;
  localparam logic [3:0] TX_LAST = 4'h9;
  localparam logic [3:0] RX_LAST = 4'h7;

  typedef enum logic [3:0] {
    ST_HUNT, ST_MEAS, ST_IDLE, ST_RXS, ST_RXD, ST_RXP, ST_TX, ST_ERR, ST_HOLD
  } sdl_state_type;
endpackage : sdl_pkg

/* sdl_onchip_debugger_unit.sv */
// serial front end and debug mode control of the on-chip debugger
// assumes apb on core_clk_i, pin pulled up outside, cpu signals on core_clk_i
//
// The implementer's own choices: the address map and the APB interface to the registers.
module sdl_onchip_debugger_unit
  import sdl_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // open drain debug pin
  input wire logic debug_serial_pin_i,
  output logic debug_serial_pin_o,
  output logic debug_serial_pin_oe_o,
  // cpu side
  input wire logic break_instruction_i,
  input wire logic stop_mode_i,
  input wire logic read_protect_option_i,
  output logic fetch_stop_o,
  output logic exit_halt_o,
  output logic wdt_refresh_o,
  output logic break_spin_o,
  output logic full_cmd_en_o,
  output logic abort_cmd_o,
  output logic sys_reset_req_o
);

  typedef struct packed {
    sdl_state_type st;
    logic sync1, sync2, pin_q;
    logic [12:0] cnt, low_cnt;
    logic [9:0] bit_per;
    logic [3:0] idx;
    logic [9:0] sh;
    logic [7:0] rx_sh, rx_data;
    logic locked, rx_valid, drive, dout;
    logic f_frame, f_coll, f_brk;
    logic dmode, bken, loop_en, looping;
    logic [1:0] strap;
    logic rst_req, abort, fetch_stop, exit_halt;
    logic wdt_ref, spin, cmd_en;
    logic [31:0] prdata;
    logic pready, pslverr;
  } sdl_regs_type;

  localparam sdl_regs_type REGS_RST = '{
    st: ST_HUNT, sync1: 1'b1, sync2: 1'b1, pin_q: 1'b1,
    cnt: 13'h0000, low_cnt: 13'h0000, bit_per: 10'h000, locked: 1'b0,
    idx: 4'h0, sh: 10'h3FF, rx_sh: 8'h00, rx_data: 8'h00, rx_valid: 1'b0,
    drive: 1'b0, dout: 1'b0, f_frame: 1'b0, f_coll: 1'b0, f_brk: 1'b0,
    dmode: CTRL_DMODE_RST, bken: CTRL_BKEN_RST, loop_en: CTRL_LOOP_RST,
    looping: 1'b0, strap: 2'h0, rst_req: 1'b0, abort: 1'b0,
    fetch_stop: 1'b0, exit_halt: 1'b0, wdt_ref: 1'b0, spin: 1'b0,
    cmd_en: 1'b0, prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0
  };

  sdl_regs_type s, n;
  logic fall, acc_done, wr_en, rd_en;
  logic tx_go, e_brk, e_frm, e_col;
  logic [12:0] bp_m1, half, brk_lim;
  logic [7:0] ctrl_rd, stat_rd;

  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == CTRL_OFS) || (a == STAT_OFS) || (a == RXD_OFS) || (a == TXD_OFS);
  endfunction : is_mapped

  assign bp_m1 = {3'h0, s.bit_per} - 13'h0001;
  assign half = {4'h0, s.bit_per[9:1]};
  assign brk_lim = {s.bit_per, 3'h0} + {3'h0, s.bit_per};
  assign fall = s.pin_q & ~s.sync2;
  assign acc_done = psel_i & penable_i & s.pready;
  assign wr_en = acc_done & pwrite_i;
  assign rd_en = acc_done & ~pwrite_i;

  always_comb begin
    ctrl_rd = 8'h00;
    ctrl_rd[CTRL_DMODE_BIT] = s.dmode;
    ctrl_rd[CTRL_BKEN_BIT] = s.bken;
    ctrl_rd[CTRL_LOOP_BIT] = s.loop_en;
    stat_rd = 8'h00;
    stat_rd[STAT_DMODE_BIT] = s.dmode;
    stat_rd[STAT_LOOP_BIT] = s.looping;
    stat_rd[STAT_LOCK_BIT] = s.locked;
    stat_rd[STAT_RXV_BIT] = s.rx_valid;
    stat_rd[STAT_TXB_BIT] = (s.st == ST_TX);
    stat_rd[STAT_FRM_BIT] = s.f_frame;
    stat_rd[STAT_COL_BIT] = s.f_coll;
    stat_rd[STAT_BRK_BIT] = s.f_brk;
  end

  always_comb begin
    n = s;
    n.sync1 = debug_serial_pin_i;
    n.sync2 = s.sync1;
    n.pin_q = s.sync2;
    n.abort = 1'b0;
    n.pready = 1'b0;
    tx_go = 1'b0;
    e_brk = 1'b0;
    e_frm = 1'b0;
    e_col = 1'b0;
    // one wait state, data flopped with pready
    if (psel_i && penable_i && !s.pready) begin
      n.pready = 1'b1;
      n.pslverr = ~is_mapped(paddr_i);
      case (paddr_i)
        CTRL_OFS: n.prdata = {24'h000000, ctrl_rd};
        STAT_OFS: n.prdata = {24'h000000, stat_rd};
        RXD_OFS: n.prdata = {24'h000000, s.rx_data};
        default: n.prdata = 32'h0000_0000;
      endcase
    end
    if (wr_en && paddr_i == CTRL_OFS) begin
      n.bken = pwdata_i[CTRL_BKEN_BIT];
      n.loop_en = pwdata_i[CTRL_LOOP_BIT];
      // clearing the bit leaves debug mode
      // read protect only lets it be set
      if (pwdata_i[CTRL_DMODE_BIT] || !read_protect_option_i) begin
        n.dmode = pwdata_i[CTRL_DMODE_BIT];
      end
    end
    // write one to clear, hardware set below wins
    if (wr_en && paddr_i == STAT_OFS) begin
      if (pwdata_i[STAT_FRM_BIT]) n.f_frame = 1'b0;
      if (pwdata_i[STAT_COL_BIT]) n.f_coll = 1'b0;
      if (pwdata_i[STAT_BRK_BIT]) n.f_brk = 1'b0;
    end
    if (wr_en && paddr_i == TXD_OFS && s.st == ST_IDLE && s.locked) begin
      tx_go = 1'b1;
      // start low, data lsb first, stop high
      n.sh = {1'b1, pwdata_i[7:0], 1'b0};
    end
    if (rd_en && paddr_i == RXD_OFS) n.rx_valid = 1'b0;
    // strap is caught once the synchroniser holds a post-reset sample
    if (s.strap != STRAP_DONE) n.strap = s.strap + 2'h1;
    // line low at reset exit enters debug
    if (s.strap == STRAP_CHK && !s.sync2) n.dmode = 1'b1;
    // opcode 00h signal, ignored when disabled
    if (break_instruction_i && s.bken) begin
      if (s.loop_en) begin
        n.looping = 1'b1;
      end else begin
        // return to breakpoint sets debug mode
        n.dmode = 1'b1;
        n.looping = 1'b0;
      end
    end
    // line low in stop mode resets all
    n.rst_req = stop_mode_i & ~s.sync2;
    if (n.rst_req) n.dmode = 1'b0;
    n.low_cnt = 13'h0000;
    if ((s.st == ST_IDLE || s.st == ST_RXS || s.st == ST_RXD || s.st == ST_RXP)
        && !s.sync2 && s.low_cnt != CNT_MAX) begin
      n.low_cnt = s.low_cnt + 13'h0001;
    end
    // nine bit times low is a break
    if (n.low_cnt != 13'h0000 && s.low_cnt >= brk_lim) e_brk = 1'b1;
    case (s.st)
      ST_HUNT: begin
        // wait for the host sync character
        if (s.strap == STRAP_DONE && fall) begin
          n.st = ST_MEAS;
          n.cnt = 13'h0001;
        end
      end
      ST_MEAS: begin
        if (!s.sync2) begin
          if (s.cnt != CNT_MAX) n.cnt = s.cnt + 13'h0001;
          if (s.cnt >= UNLK_BRK_CYC) e_brk = 1'b1;
        // up to 512 cycles per bit
        end else if (s.cnt >= SYNC_MIN && s.cnt <= SYNC_MAX) begin
          // eight low bits, divide by eight
          n.bit_per = s.cnt[12:3];
          n.locked = 1'b1;
          n.st = ST_IDLE;
        end else begin
          n.st = ST_HUNT;
        end
      end
      ST_IDLE: begin
        if (tx_go) begin
          n.st = ST_TX;
          n.cnt = 13'h0000;
          n.idx = 4'h0;
          n.drive = 1'b1;
        end else if (fall) begin
          n.st = ST_RXS;
          n.cnt = 13'h0001;
        end
      end
      ST_RXS: begin
        if (s.sync2) begin
          n.st = ST_IDLE;
        end else if (s.cnt >= half) begin
          n.st = ST_RXD;
          n.cnt = 13'h0000;
          n.idx = 4'h0;
        end else begin
          n.cnt = s.cnt + 13'h0001;
        end
      end
      ST_RXD: begin
        if (s.cnt == bp_m1) begin
          n.cnt = 13'h0000;
          n.rx_sh = {s.sync2, s.rx_sh[7:1]};
          n.idx = s.idx + 4'h1;
          if (s.idx == RX_LAST) n.st = ST_RXP;
        end else begin
          n.cnt = s.cnt + 13'h0001;
        end
      end
      ST_RXP: begin
        if (s.cnt == bp_m1) begin
          // low stop bit is framing error
          if (!s.sync2) begin
            e_frm = 1'b1;
          end else begin
            n.rx_data = s.rx_sh;
            n.rx_valid = 1'b1;
            n.st = ST_IDLE;
          end
        end else begin
          n.cnt = s.cnt + 13'h0001;
        end
      end
      ST_TX: begin
        // released bit read low is collision
        // host break while sending lands here
        if (s.cnt == half && !s.drive && !s.sync2) e_col = 1'b1;
        if (s.cnt == bp_m1) begin
          n.cnt = 13'h0000;
          n.sh = {1'b1, s.sh[9:1]};
          n.idx = s.idx + 4'h1;
          if (s.idx == TX_LAST) begin
            n.st = ST_IDLE;
            n.drive = 1'b0;
          end else begin
            n.drive = ~s.sh[1];
          end
        end else begin
          n.cnt = s.cnt + 13'h0001;
        end
      end
      ST_ERR: begin
        // hold the line low for the full count
        if (s.cnt == BRK_TX_CYC - 13'h0001) begin
          n.st = ST_HOLD;
          n.cnt = 13'h0000;
          n.drive = 1'b0;
        end else begin
          n.cnt = s.cnt + 13'h0001;
        end
      end
      ST_HOLD: begin
        // stay in reset until line high
        if (!s.sync2) begin
          n.cnt = 13'h0000;
        end else if (s.cnt == HOLD_HI_CYC) begin
          n.st = ST_HUNT;
          n.cnt = 13'h0000;
        end else begin
          n.cnt = s.cnt + 13'h0001;
        end
      end
      default: begin
        n.st = ST_HUNT;
        n.drive = 1'b0;
      end
    endcase
    // control and debug mode untouched here
    if (e_brk || e_frm || e_col) begin
      n.st = ST_ERR;
      n.cnt = 13'h0000;
      n.idx = 4'h0;
      n.locked = 1'b0;
      n.rx_valid = 1'b0;
      n.abort = 1'b1;
      n.drive = 1'b1;
      n.low_cnt = 13'h0000;
      if (e_brk) n.f_brk = 1'b1;
      if (e_frm) n.f_frame = 1'b1;
      if (e_col) n.f_coll = 1'b1;
    end
    // fetch stops, halt exits, watchdog fed
    n.fetch_stop = n.dmode;
    n.exit_halt = n.dmode;
    n.wdt_ref = n.dmode;
    // dropping loop enable releases the spin
    n.spin = n.looping & n.loop_en;
    // full command set only when stopped
    n.cmd_en = n.dmode & ~n.looping;
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      s <= REGS_RST;
    end else begin
      s <= n;
    end
  end

  assign prdata_o = s.prdata;
  assign pready_o = s.pready;
  assign pslverr_o = s.pslverr;
  assign debug_serial_pin_o = s.dout;
  assign debug_serial_pin_oe_o = s.drive;
  assign fetch_stop_o = s.fetch_stop;
  assign exit_halt_o = s.exit_halt;
  assign wdt_refresh_o = s.wdt_ref;
  assign break_spin_o = s.spin;
  assign full_cmd_en_o = s.cmd_en;
  assign abort_cmd_o = s.abort;
  assign sys_reset_req_o = s.rst_req;

  // helper: cycles spent sending the error break
  logic [12:0] err_run_ff;
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      err_run_ff <= 13'h0000;
    end else if (s.st == ST_ERR) begin
      err_run_ff <= err_run_ff + 13'h0001;
    end else begin
      err_run_ff <= 13'h0000;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  chk_err_break_len: assert property (
    $fell(s.st == ST_ERR) |-> $past(err_run_ff) == 13'h0FFF)
    else $error("error break length wrong");
  chk_err_drives: assert property (
    (s.st == ST_ERR) |-> debug_serial_pin_oe_o && !s.locked)
    else $error("error break not driven");
  chk_frame_error: assert property (
    (s.st == ST_RXP && s.cnt == bp_m1 && !s.sync2)
      |=> s.f_frame && s.st == ST_ERR && abort_cmd_o)
    else $error("framing error missed");
  chk_half_duplex: assert property (
    (s.st inside {ST_RXS, ST_RXD, ST_RXP, ST_IDLE, ST_HUNT}) |-> !debug_serial_pin_oe_o)
    else $error("driving while receiving");
  chk_collision_seen: assert property (
    (s.st == ST_TX && s.cnt == half && !s.drive && !s.sync2) |=> s.f_coll ##1 s.st == ST_ERR)
    else $error("collision missed");
  chk_bkpt_enter: assert property (
    (break_instruction_i && s.bken && !s.loop_en && !stop_mode_i) |=> s.dmode [*2])
    else $error("breakpoint did not enter debug");
  chk_loop_flag: assert property (
    (break_instruction_i && s.bken && s.loop_en && !wr_en) |=> s.looping ##1 break_spin_o)
    else $error("loop flag not set");
  chk_rp_keep: assert property (
    (read_protect_option_i && s.dmode && wr_en && paddr_i == CTRL_OFS && !stop_mode_i)
      |=> s.dmode)
    else $error("debug mode cleared under protect");
  chk_hold_low: assert property (
    (s.st == ST_HOLD && !s.sync2) |=> s.st == ST_HOLD)
    else $error("left reset while line low");
  chk_ctrl_kept: assert property (
    (s.st == ST_ERR && !wr_en && !stop_mode_i && !break_instruction_i)
      |=> $stable(s.dmode) && $stable(s.bken))
    else $error("break changed control");
  chk_stop_reset: assert property (
    (stop_mode_i && !s.sync2) |=> sys_reset_req_o ##1 !s.dmode)
    else $error("stop mode reset missed");
  chk_mode_outs: assert property (
    $rose(s.dmode) |=> fetch_stop_o && exit_halt_o && wdt_refresh_o)
    else $error("debug mode outputs missing");
  chk_lock_rate: assert property (
    (s.st == ST_MEAS && s.sync2 && s.cnt >= SYNC_MIN && s.cnt <= SYNC_MAX)
      |=> s.locked && s.bit_per == $past(s.cnt[12:3]))
    else $error("autobaud lock wrong");

  cov_lock: cover property ($rose(s.locked));
  cov_rx_char: cover property ($rose(s.rx_valid));
  cov_tx_done: cover property (s.st == ST_TX ##1 s.st == ST_IDLE);
  cov_host_break: cover property ($rose(s.f_brk));

endmodule : sdl_onchip_debugger_unit

/* sdl_debug_host.sv */
// host side model of the single pin debug link
// assumes the bench resolves the wire from both pull enables and a pull-up
module sdl_debug_host #(
  // 16 cycles a bit, under clk/8
  parameter int BIT_CYC = 16
) (
  // clock and resolved wire
  input wire logic core_clk_i,
  input wire logic line_i,
  // high while the host pulls the line low
  output logic pull_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial pull_o = 1'b0;

  task automatic send_byte(input logic [7:0] d, input logic stop_ok);
    @(posedge core_clk_i);
    pull_o <= 1'b1;
    repeat (BIT_CYC) @(posedge core_clk_i);
    for (int i = 0; i < 8; i++) begin
      pull_o <= ~d[i];
      repeat (BIT_CYC) @(posedge core_clk_i);
    end
    // released line floats high by the pull-up
    pull_o <= ~stop_ok;
    repeat (BIT_CYC) @(posedge core_clk_i);
    pull_o <= 1'b0;
    repeat (2 * BIT_CYC) @(posedge core_clk_i);
  endtask : send_byte

  // break, allowed even over device traffic
  task automatic hold_low(input int n);
    @(posedge core_clk_i);
    pull_o <= 1'b1;
    repeat (n) @(posedge core_clk_i);
    pull_o <= 1'b0;
  endtask : hold_low

  // bounded wait for a start edge from the device
  task automatic wait_start();
    int n;
    n = 0;
    while (line_i !== 1'b0 && n < 4000) begin
      @(posedge core_clk_i);
      n++;
    end
  endtask : wait_start

  task automatic recv_byte(output logic [7:0] d, output logic stop_ok);
    wait_start();
    repeat (BIT_CYC / 2) @(posedge core_clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge core_clk_i);
      d[i] = line_i;
    end
    repeat (BIT_CYC) @(posedge core_clk_i);
    stop_ok = line_i;
    // let the stop bit end, the device still owns the frame
    repeat (BIT_CYC) @(posedge core_clk_i);
  endtask : recv_byte

  // pulls low across two high data bits of a device char
  task automatic jam();
    wait_start();
    repeat (3 * BIT_CYC) @(posedge core_clk_i);
    pull_o <= 1'b1;
    repeat (2 * BIT_CYC) @(posedge core_clk_i);
    pull_o <= 1'b0;
  endtask : jam
endmodule : sdl_debug_host

/* tb_single_pin_debug_link.sv */
// self-checking bench for the on-chip debugger front end
// assumes 20 MHz clock, apb master here, host model on the pulled-up pin
module tb_single_pin_debug_link
  import sdl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, pin_o, pin_oe, host_pull, line, er, ok;
  logic bi = 1'b0, stop_m = 1'b0, rp = 1'b0;
  logic fetch, exit_halt, wdt, spin, fullcmd, abort, sysreq;
  logic [7:0] b;
  int bad_count = 0, tests_run = 0, aborts = 0, len;

  // open drain: low if either side pulls
  assign line = !(pin_oe || host_pull);

  sdl_onchip_debugger_unit u_dut (.core_clk_i(clk), .sys_rst_i(rst), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .debug_serial_pin_i(line), .debug_serial_pin_o(pin_o), .debug_serial_pin_oe_o(pin_oe),
    .break_instruction_i(bi), .stop_mode_i(stop_m), .read_protect_option_i(rp),
    .fetch_stop_o(fetch), .exit_halt_o(exit_halt), .wdt_refresh_o(wdt),
    .break_spin_o(spin), .full_cmd_en_o(fullcmd), .abort_cmd_o(abort),
    .sys_reset_req_o(sysreq));

  sdl_debug_host #(.BIT_CYC(16)) u_host (.core_clk_i(clk), .line_i(line), .pull_o(host_pull));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    if (abort === 1'b1) aborts++;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t ns: %s got %h want %h", $time, msg, got, exp);
    end
  endtask : check

  function automatic logic [31:0] bitv(input int n);
    return 32'h1 << n;
  endfunction : bitv

  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    check(32'(n < 50), 32'h1, "apb ready");
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
    repeat (2) @(posedge clk);
  endtask : wr

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string msg);
    apb(a, 1'b0, 32'h0);
    check(rd, exp, msg);
  endtask : rd_chk

  // counts cycles of one device pull-down run
  task automatic brk_len();
    int w;
    w = 0;
    len = 0;
    while (pin_oe !== 1'b1 && w < 3000) begin
      @(posedge clk);
      w++;
    end
    while (pin_oe === 1'b1 && len < 5000) begin
      @(posedge clk);
      len++;
    end
  endtask : brk_len

  task automatic bp();
    @(posedge clk);
    bi <= 1'b1;
    @(posedge clk);
    bi <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : bp

  task automatic do_reset();
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (10) @(posedge clk);
  endtask : do_reset

  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    $display("mismatch at %0t ns: watchdog expired", $time);
    complete_run();
  end

  initial begin
    do_reset();
    rd_chk(CTRL_OFS, 32'h0, "ctrl reset");
    rd_chk(STAT_OFS, 32'h0, "stat reset");
    apb(12'h010, 1'b0, 32'h0);
    check(32'(er), 32'h1, "unmapped err");
    u_host.send_byte(8'h80, 1'b1);
    rd_chk(STAT_OFS, bitv(STAT_LOCK_BIT), "locked");
    u_host.send_byte(8'hA5, 1'b1);
    rd_chk(STAT_OFS, bitv(STAT_LOCK_BIT) | bitv(STAT_RXV_BIT), "rx valid");
    rd_chk(RXD_OFS, 32'hA5, "rx byte");
    apb(TXD_OFS, 1'b1, 32'h3C);
    u_host.recv_byte(b, ok);
    check({23'h0, ok, b}, 32'h13C, "tx char");
    fork
      u_host.send_byte(8'h55, 1'b0);
      brk_len();
    join
    check(32'(len), 32'(BRK_TX_CYC), "frame break length");
    check({31'h0, pin_o}, 32'h0, "pin data low");
    repeat (10) @(posedge clk);
    rd_chk(STAT_OFS, bitv(STAT_FRM_BIT), "frame flag");
    check(32'(aborts), 32'h1, "abort on frame");
    wr(STAT_OFS, bitv(STAT_FRM_BIT));
    rd_chk(STAT_OFS, 32'h0, "flag cleared");
    u_host.send_byte(8'h80, 1'b1);
    wr(CTRL_OFS, 32'h80);
    check({29'h0, fetch, exit_halt, wdt}, 32'h7, "debug mode outs");
    fork
      u_host.hold_low(4500);
      brk_len();
    join
    check(32'(len), 32'(BRK_TX_CYC), "echo break length");
    repeat (10) @(posedge clk);
    rd_chk(CTRL_OFS, 32'h80, "ctrl kept");
    rd_chk(STAT_OFS, bitv(STAT_BRK_BIT) | bitv(STAT_DMODE_BIT), "break flag");
    wr(STAT_OFS, bitv(STAT_BRK_BIT));
    u_host.send_byte(8'h80, 1'b1);
    rd_chk(STAT_OFS, bitv(STAT_LOCK_BIT) | bitv(STAT_DMODE_BIT), "relock");
    apb(TXD_OFS, 1'b1, 32'hFF);
    u_host.jam();
    repeat (4400) @(posedge clk);
    rd_chk(STAT_OFS, bitv(STAT_COL_BIT) | bitv(STAT_DMODE_BIT), "collision");
    check(32'(aborts), 32'h3, "abort count");
    wr(STAT_OFS, 32'hE0);
    rp <= 1'b1;
    wr(CTRL_OFS, 32'h0);
    rd_chk(CTRL_OFS, 32'h80, "protect keeps mode");
    rp <= 1'b0;
    wr(CTRL_OFS, 32'h0);
    check({31'h0, fetch}, 32'h0, "mode left");
    bp();
    check({31'h0, fetch}, 32'h0, "disabled break nop");
    wr(CTRL_OFS, 32'h40);
    bp();
    rd_chk(CTRL_OFS, 32'hC0, "break enters debug");
    check({30'h0, fetch, fullcmd}, 32'h3, "stopped full cmds");
    wr(CTRL_OFS, 32'h60);
    bp();
    rd_chk(STAT_OFS, bitv(STAT_LOOP_BIT), "looping flag");
    check({29'h0, spin, fetch, fullcmd}, 32'h4, "spin no cmds");
    wr(CTRL_OFS, 32'h40);
    check({31'h0, spin}, 32'h0, "loop stopped");
    bp();
    check({30'h0, fetch, fullcmd}, 32'h3, "back in debug");
    stop_m <= 1'b1;
    u_host.hold_low(8);
    check({30'h0, sysreq, fetch}, 32'h2, "stop mode reset");
    stop_m <= 1'b0;
    fork
      u_host.hold_low(40);
      do_reset();
    join
    check({31'h0, fetch}, 32'h1, "strap enters debug");
    complete_run();
  end
endmodule : tb_single_pin_debug_link
